// File: hdl/rrb_defs.svh
// Holds register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and design modules.
`ifndef RRB_DEFS_SVH
`define RRB_DEFS_SVH
`define RRB_OFF_POLL          8'h34
`define RRB_OFF_INTERVAL      8'hd4
`define RRB_OFF_COMMAND       9'h100
`define RRB_ADDR_W            24
`define RRB_BIT_FORCE         20
`define RRB_BIT_PERIODIC_EN   16
`define RRB_BIT_FP_EN         17
`define RRB_BIT_MASTER        18
`define RRB_BIT_MARKER        0
`define RRB_BIT_BUSY          1
`define RRB_BIT_PAUSED        2
`define RRB_INTERVAL_RESET    16'h0001
`define RRB_BLOCK_RESET       8'h01
`define RRB_CLOCK_MHZ         40
`define RRB_SHORT_BUSY_US     3
`define RRB_SHORT_BUSY_CYC    (`RRB_SHORT_BUSY_US * `RRB_CLOCK_MHZ)
`endif

// File: hdl/rrb_pkg.sv
// Holds the shared types of the resync busy control block.
// Assumes the constants header is on the include path.
`include "rrb_defs.svh"
package rrb_pkg;
  // One trigger as it leaves the distribution logic.
  typedef struct packed {
    logic        valid;
    logic        resync;
    logic [7:0]  event_type;
    logic [31:0] event_number;
    logic [47:0] time_stamp;
  } rrb_trig_t;
  // Register bus request.
  typedef struct packed {
    logic        write;
    logic        read;
    logic [23:0] addr;
    logic [31:0] wdata;
  } rrb_bus_t;
  typedef enum logic [1:0] {
    RRB_RUN,
    RRB_SHORT_BUSY,
    RRB_WAIT_FE
  } rrb_sup_state_t;
endpackage

// File: hdl/rrb_period.sv
// Holds the periodic block and resync interval counters.
// Assumes a trigger pulse per event and configuration held stable while running.
`timescale 1ns/100ps
`include "rrb_defs.svh"
module rrb_period (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic [7:0]  block_size,
  input  wire logic [15:0] interval,
  input  wire logic        trig_step,
  output logic             mark_now
);
  logic [7:0]  evt_cnt;
  logic [7:0]  next_evt_cnt;
  logic [15:0] blk_cnt;
  logic [15:0] blk_next;
  logic        last_evt;
  logic        last_blk;

  ////////////////////////////////////////////////////////////////////////////////
  // A block size or interval of zero is treated as one so counting never stalls.
  always_comb begin
    last_evt = (evt_cnt + 8'h01 >= block_size);
    last_blk = (blk_cnt + 16'h0001 >= interval);
    // Mark last event of every N blocks.
    mark_now = enable && trig_step && last_evt && last_blk;
    next_evt_cnt = evt_cnt;
    blk_next = blk_cnt;
    if (!enable) begin
      next_evt_cnt = 8'h00;
      blk_next = 16'h0000;
    end else if (trig_step) begin
      // Events per block up to 255.
      next_evt_cnt = last_evt ? 8'h00 : evt_cnt + 8'h01;
      if (last_evt) begin
        blk_next = last_blk ? 16'h0000 : blk_cnt + 16'h0001;
      end
    end
  end

  // Counter registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_cnt <= 8'h00;
      blk_cnt <= 16'h0000;
    end else if (ce) begin
      evt_cnt <= next_evt_cnt;
      blk_cnt <= blk_next;
    end
  end
endmodule

// File: hdl/rrb_short_busy.sv
// Holds the short busy timer started after each resync event.
// Assumes a single-cycle start pulse.
`timescale 1ns/100ps
`include "rrb_defs.svh"
module rrb_short_busy (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy
);
  localparam logic [7:0] CYCLES = 8'(`RRB_SHORT_BUSY_CYC);
  logic [7:0] count;
  logic [7:0] next_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Reload on start; count down to zero.
  always_comb begin
    if (start) begin
      next_count = CYCLES;
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 8'h00;
    end else if (ce) begin
      count <= next_count;
    end
  end

  assign busy = (count != 8'h00);
endmodule

// File: hdl/rrb_top.sv
// Holds the readout resync busy control: supervisor side and front-end side.
// Assumes a simple synchronous register port, one trigger request pulse per event,
// and single-cycle pulses for resync receipt and readout acknowledge.
//
// Behaviour
// - Periodic resync marks last event of N blocks.
// - Block size programmable up to 255 events.
// - Periodic resync keeps original event type.
// - Forced resync is extra event, type zero.
// - Command bit 20 requests forced resync.
// - Front-panel input may also force resync.
// - After resync: 3 us busy, stop triggers.
// - Front-end sets busy and poll marker.
// - Front-end busy arrives within 3 us.
// - Readout acknowledge clears front-end resync busy.
// - Pipelined: only final acknowledge clears busy.
// - Resume triggers after all busy clear.
// - Event number holds, continues; the time stamp keeps counting while paused.
`timescale 1ns/100ps
`include "rrb_defs.svh"
module rrb_top (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire rrb_pkg::rrb_bus_t bus,
  output logic [31:0]            rdata,
  output logic                   rvalid,
  input  wire logic [7:0]        block_size,
  input  wire logic              trig_req,
  input  wire logic [7:0]        trig_type,
  input  wire logic              counter_reset,
  input  wire logic              fp_resync,
  input  wire logic              fe_busy_in,
  output rrb_pkg::rrb_trig_t     trig_out,
  input  wire logic              resync_rx,
  input  wire logic              block_done,
  input  wire logic              readout_ack,
  output logic                   busy_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register file state.
  logic [15:0] interval;
  logic [15:0] next_interval;
  logic        periodic_en;
  logic        next_periodic_en;
  logic        fp_en;
  logic        next_fp_en;
  logic        master;
  logic        next_master;
  logic        force_pend;
  logic        next_force_pend;
  logic [31:0] next_rdata;
  logic        next_rvalid;

  // Matches a register on the low nine address bits and demands zero above them,
  // so stray upper addresses are ignored rather than aliased onto a register.
  function automatic logic hit(input logic [23:0] a, input logic [8:0] off);
    hit = (a[8:0] == off) && (a[23:9] == 15'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Supervisor state.
  rrb_pkg::rrb_sup_state_t state;
  rrb_pkg::rrb_sup_state_t next_state;
  logic [31:0]             evt_num;
  logic [31:0]             next_evt_num;
  logic [47:0]             tstamp;
  logic [47:0]             next_tstamp;
  rrb_pkg::rrb_trig_t      next_trig_out;
  logic                    fp_prev;
  logic                    sb_start;
  logic                    sb_busy;
  logic                    mark_now;
  logic                    trig_step;
  logic                    fire_force;

  ////////////////////////////////////////////////////////////////////////////////
  // Front-end state.
  logic       fe_busy;
  logic       next_fe_busy;
  logic       marker;
  logic       next_marker;
  logic [7:0] pending;
  logic [7:0] next_pending;

  // A refused request is simply lost, so the requester must keep it up.
  // Triggers pass only while running and no resync insertion takes the slot.
  assign trig_step = (state == rrb_pkg::RRB_RUN) && trig_req && !fire_force;

  // Periodic marking runs only in master mode; on a front-end board the
  // counters stay cleared, so a later switch to master starts a fresh count.
  rrb_period u_period (
    .clock      (clock),
    .rst        (rst),
    .ce         (ce),
    .enable     (periodic_en && master),
    .block_size (block_size),
    .interval   (interval),
    .trig_step  (trig_step),
    .mark_now   (mark_now)
  );

  // The short busy bridges the time the front-end busy needs to come back.
  rrb_short_busy u_short (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .start (sb_start),
    .busy  (sb_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode. A poll read clears the marker; a new resync that lands in
  // the same cycle still wins, so no marker is lost.
  always_comb begin
    next_interval = interval;
    next_periodic_en = periodic_en;
    next_fp_en = fp_en;
    next_master = master;
    next_force_pend = force_pend;
    next_rdata = 32'h0000_0000;
    next_rvalid = bus.read;
    if (bus.write && hit(bus.addr, {1'b0, `RRB_OFF_INTERVAL})) begin
      next_interval = bus.wdata[15:0];
      next_periodic_en = bus.wdata[`RRB_BIT_PERIODIC_EN];
    end
    if (bus.write && hit(bus.addr, `RRB_OFF_COMMAND)) begin
      next_fp_en = bus.wdata[`RRB_BIT_FP_EN];
      next_master = bus.wdata[`RRB_BIT_MASTER];
    end
    if (fire_force) begin
      next_force_pend = 1'b0;
    end
    if (bus.write && hit(bus.addr, `RRB_OFF_COMMAND) && bus.wdata[`RRB_BIT_FORCE]) begin
      next_force_pend = 1'b1;
    end
    if (fp_en && fp_resync && !fp_prev) begin
      next_force_pend = 1'b1;
    end
    if (bus.read) begin
      if (hit(bus.addr, {1'b0, `RRB_OFF_POLL})) begin
        next_rdata[`RRB_BIT_MARKER] = marker;
        next_rdata[`RRB_BIT_BUSY] = fe_busy;
        next_rdata[`RRB_BIT_PAUSED] = (state != rrb_pkg::RRB_RUN);
      end else if (hit(bus.addr, {1'b0, `RRB_OFF_INTERVAL})) begin
        next_rdata[15:0] = interval;
        next_rdata[`RRB_BIT_PERIODIC_EN] = periodic_en;
      end else if (hit(bus.addr, `RRB_OFF_COMMAND)) begin
        next_rdata[`RRB_BIT_FORCE] = force_pend;
        next_rdata[`RRB_BIT_FP_EN] = fp_en;
        next_rdata[`RRB_BIT_MASTER] = master;
      end
    end
  end

  // Register file flops. The front-panel level is sampled here too; its
  // detector starts from the idle low level, so no false edge follows reset.
  // Read data is cleared on idle cycles so a stale word never lingers.
  always_ff @(posedge clock) begin
    if (rst) begin
      interval <= `RRB_INTERVAL_RESET;
      periodic_en <= 1'b0;
      fp_en <= 1'b0;
      master <= 1'b0;
      force_pend <= 1'b0;
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
      fp_prev <= 1'b0;
    end else if (ce) begin
      interval <= next_interval;
      periodic_en <= next_periodic_en;
      fp_en <= next_fp_en;
      master <= next_master;
      force_pend <= next_force_pend;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      fp_prev <= fp_resync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supervisor sequencing. A forced resync takes priority over a waiting
  // trigger, which the requester simply holds until the pause after the resync ends.
  always_comb begin
    fire_force = master && force_pend && (state == rrb_pkg::RRB_RUN);
    next_state = state;
    next_evt_num = evt_num;
    next_tstamp = tstamp + 48'h1;
    next_trig_out = '0;
    sb_start = 1'b0;
    unique case (state)
      rrb_pkg::RRB_RUN: begin
        if (fire_force) begin
          next_trig_out.valid = 1'b1;
          next_trig_out.resync = 1'b1;
          next_trig_out.event_type = 8'h00;
          next_trig_out.event_number = evt_num + 32'h1;
          next_trig_out.time_stamp = tstamp;
          next_evt_num = evt_num + 32'h1;
          sb_start = 1'b1;
          next_state = rrb_pkg::RRB_SHORT_BUSY;
        end else if (trig_step) begin
          next_trig_out.valid = 1'b1;
          next_trig_out.event_type = trig_type;
          next_trig_out.resync = mark_now;
          next_trig_out.event_number = evt_num + 32'h1;
          next_trig_out.time_stamp = tstamp;
          next_evt_num = evt_num + 32'h1;
          if (mark_now) begin
            sb_start = 1'b1;
            next_state = rrb_pkg::RRB_SHORT_BUSY;
          end
        end
      end
      rrb_pkg::RRB_SHORT_BUSY: begin
        // No front-end busy may have arrived yet, so the wait for the front
        // ends only starts once the short busy has run out.
        // Triggers stopped during short busy.
        if (!sb_busy) begin
          next_state = rrb_pkg::RRB_WAIT_FE;
        end
      end
      rrb_pkg::RRB_WAIT_FE: begin
        // Resume when all front ends free.
        if (!fe_busy_in) begin
          next_state = rrb_pkg::RRB_RUN;
        end
      end
    endcase
    if (counter_reset) begin
      next_evt_num = 32'h0;
      next_tstamp = 48'h0;
    end
  end

  // Supervisor flops. The time stamp counts every enabled cycle, also while
  // paused, so it keeps tracking real time; only counter_reset clears it.
  // The trigger word is registered so all its fields change together.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= rrb_pkg::RRB_RUN;
      evt_num <= 32'h0;
      tstamp <= 48'h0;
      trig_out <= '0;
    end else if (ce) begin
      state <= next_state;
      evt_num <= next_evt_num;
      tstamp <= next_tstamp;
      trig_out <= next_trig_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Front-end side. Outstanding blocks are counted so that only the final
  // acknowledge releases busy; the count saturates rather than wraps.
  always_comb begin
    next_fe_busy = fe_busy;
    next_marker = marker;
    next_pending = pending;
    // A block finished and acknowledged in one cycle leaves the count as it is.
    if (block_done && !readout_ack && pending != 8'hff) begin
      next_pending = pending + 8'h01;
    end else if (readout_ack && !block_done && pending != 8'h00) begin
      next_pending = pending - 8'h01;
    end
    if (fe_busy && readout_ack && next_pending == 8'h00) begin
      next_fe_busy = 1'b0;
    end
    if (bus.read && hit(bus.addr, {1'b0, `RRB_OFF_POLL})) begin
      next_marker = 1'b0;
    end
    if (resync_rx) begin
      next_fe_busy = 1'b1;
      next_marker = 1'b1;
    end
  end

  // Front-end flops. A pending count above the real one only delays the busy
  // release, which is the safe direction for the readout.
  always_ff @(posedge clock) begin
    if (rst) begin
      fe_busy <= 1'b0;
      marker <= 1'b0;
      pending <= 8'h00;
    end else if (ce) begin
      fe_busy <= next_fe_busy;
      marker <= next_marker;
      pending <= next_pending;
    end
  end

  // The front-end busy is a flop and the short busy a compare on a counter flop; the merge adds one gate and
  // the front-end part follows a resync receipt by a single cycle.
  // Busy registered one cycle after receipt.
  assign busy_out = fe_busy || sb_busy;
endmodule

// File: test/rrb_top_assertions.sv
// Checker for the resync busy control, watching the top ports only.
// Assumes one clock domain and ce held high while checked.
`timescale 1ns/100ps
module rrb_top_assertions (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               ce,
  input wire rrb_pkg::rrb_bus_t  bus,
  input wire logic [31:0]        rdata,
  input wire logic               rvalid,
  input wire logic [7:0]         block_size,
  input wire logic               trig_req,
  input wire logic [7:0]         trig_type,
  input wire logic               counter_reset,
  input wire logic               fp_resync,
  input wire logic               fe_busy_in,
  input wire rrb_pkg::rrb_trig_t trig_out,
  input wire logic               resync_rx,
  input wire logic               block_done,
  input wire logic               readout_ack,
  input wire logic               busy_out
);
  logic [7:0]  sb_cnt;
  logic        paused;
  logic        seen;
  logic [31:0] last_num;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Tracks the pause after each resync event; the first cycles are left out
  // because the design may take one trigger in the marking cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      sb_cnt <= 8'h00;
      paused <= 1'b0;
    end else if (trig_out.valid && trig_out.resync) begin
      sb_cnt <= 8'h77;
      paused <= 1'b1;
    end else begin
      if (sb_cnt != 8'h00) sb_cnt <= sb_cnt - 8'h01;
      if (sb_cnt == 8'h00 && !fe_busy_in) paused <= 1'b0;
    end
  end
  // Remembers the last event number handed out.
  always_ff @(posedge clock) begin
    if (rst || counter_reset) seen <= 1'b0;
    else if (trig_out.valid) seen <= 1'b1;
    if (trig_out.valid) last_num <= trig_out.event_number;
  end
  ////////////////////////////////////////////////////////////////////////////////
  fe_busy_set_a: assert property (resync_rx |=> busy_out)
    else $error("busy not raised after resync receipt");
  fe_busy_hold_a: assert property (busy_out && !readout_ack && !paused && sb_cnt == 8'h00 |=> busy_out)
    else $error("busy dropped without acknowledge");
  short_busy_a: assert property (trig_out.valid && trig_out.resync |-> ##2 busy_out [*8])
    else $error("short busy missing after resync event");
  trig_pause_a: assert property (sb_cnt != 8'h00 && sb_cnt < 8'h76 |-> !trig_out.valid)
    else $error("trigger during short busy");
  resume_wait_a: assert property (paused && $past(fe_busy_in, 2) |-> !trig_out.valid)
    else $error("trigger while front ends busy");
  type_kept_a: assert property (trig_out.valid && trig_out.event_type != 8'h00 |-> trig_out.event_type == $past(trig_type))
    else $error("event type changed");
  evnum_step_a: assert property (trig_out.valid && seen |-> trig_out.event_number == last_num + 32'h1)
    else $error("event number not continuous");
  rd_answer_a: assert property (bus.read |=> rvalid)
    else $error("read not answered");
  cover property (trig_out.valid && trig_out.resync && trig_out.event_type == 8'h00);
  cover property (trig_out.valid && trig_out.resync && trig_out.event_type != 8'h00);
  cover property ($fell(busy_out));
endmodule
bind rrb_top rrb_top_assertions i_rrb_top_assertions (.clock(clock), .rst(rst), .ce(ce),
  .bus(bus), .rdata(rdata), .rvalid(rvalid), .block_size(block_size), .trig_req(trig_req),
  .trig_type(trig_type), .counter_reset(counter_reset), .fp_resync(fp_resync),
  .fe_busy_in(fe_busy_in), .trig_out(trig_out), .resync_rx(resync_rx),
  .block_done(block_done), .readout_ack(readout_ack), .busy_out(busy_out));

// File: test/rrb_fe_model.sv
// Front-end crate model: answers each resync event with a merged busy.
// Assumes the trigger output of the top and a bench-chosen reply delay.
`timescale 1ns/100ps
module rrb_fe_model #(
  parameter int HOLD = 200
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire rrb_pkg::rrb_trig_t trig,
  input  wire logic [7:0]         dly,
  output logic                    fe_busy
);
  logic [9:0] cnt;
  // busy reply window
  // Busy rises dly cycles after the event and drops once the crates drain.
  always_ff @(posedge clock) begin
    if (rst) cnt <= 10'h000;
    else if (trig.valid && trig.resync) cnt <= 10'(dly) + 10'(HOLD);
    else if (cnt != 10'h000) cnt <= cnt - 10'h001;
  end
  assign fe_busy = cnt != 10'h000 && cnt <= 10'(HOLD);
endmodule

// File: test/test_rrb_top.sv
// Self-checking bench for the resync busy control top.
// Assumes the front-end model on the busy return path.
`timescale 1ns/100ps
module test_rrb_top;
  localparam int FE_HOLD = 200;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  rrb_pkg::rrb_bus_t  bus = '0;
  logic [31:0]        rdata;
  logic               rvalid;
  logic               trig_req = 1'b0;
  logic [7:0]         block_size = 8'h02;
  logic [7:0]         trig_type = 8'h5a;
  logic               counter_reset = 1'b0;
  logic               fp_resync = 1'b0;
  logic               fe_busy_in;
  logic               resync_rx = 1'b0;
  logic               block_done = 1'b0;
  logic               readout_ack = 1'b0;
  logic               busy_out;
  logic [7:0]         dly = 8'h01;
  rrb_pkg::rrb_trig_t trig_out;
  int                 mismatches = 0;
  int                 n_tests = 0;
  always #12.5 clock = ~clock;
  rrb_top i_rrb_top (.clock(clock), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
    .rvalid(rvalid), .block_size(block_size), .trig_req(trig_req), .trig_type(trig_type),
    .counter_reset(counter_reset), .fp_resync(fp_resync), .fe_busy_in(fe_busy_in),
    .trig_out(trig_out), .resync_rx(resync_rx), .block_done(block_done),
    .readout_ack(readout_ack), .busy_out(busy_out));
  rrb_fe_model #(.HOLD(FE_HOLD)) i_rrb_fe_model (.clock(clock), .rst(rst),
    .trig(trig_out), .dly(dly), .fe_busy(fe_busy_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clock) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock) bus <= '0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    @(posedge clock) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock) bus <= '0;
    #1 chk(rdata, exp);
  endtask
  // Waits for the next trigger, bounded so a stuck pause cannot hang.
  task automatic next_ev(output int gap);
    gap = 0;
    do begin
      @(posedge clock);
      #1 gap++;
    end while (trig_out.valid !== 1'b1 && gap < 2000);
  endtask
  task automatic wait_sync(output int n);
    int gap;
    n = 0;
    do begin
      next_ev(gap);
      n++;
    end while (trig_out.resync !== 1'b1 && n < 300);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(24'h0000d4, 32'h00000001);
    wr(24'h0000d4, 32'h0001ffff);
    rd(24'h0000d4, 32'h0001ffff);
    rd(24'h000080, 32'h00000000);
    rd(24'h000100, 32'h00000000);
    rd(24'h000034, 32'h00000000);
    wr(24'h0000d4, 32'h00000001);
  endtask
  // Rounds show the block count restarting after each mark; the last round
  // uses the largest block with N of one, and the rounds after the first a second event type.
  task automatic t_periodic;
    int n;
    wr(24'h000100, 32'h00040000);
    wr(24'h0000d4, 32'h00010003);
    trig_req <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      trig_type <= k ? 8'h3c : 8'h5a;
      if (k == 2) begin
        block_size <= 8'hff;
        wr(24'h0000d4, 32'h00010001);
      end
      wait_sync(n);
      chk(32'(n), (k == 2) ? 32'hff : 32'h6);
      chk(trig_out.event_type, k ? 32'h3c : 32'h5a);
    end
    @(posedge clock) trig_req <= 1'b0;
    wr(24'h0000d4, 32'h00000001);
    repeat (400) @(posedge clock);
  endtask
  // Forced by command, then by the front panel, with prompt and slow crates.
  task automatic t_force;
    int gap;
    int n;
    wr(24'h000100, 32'h00060000);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      dly <= s ? 8'h64 : 8'h01;
      trig_req <= 1'b1;
      if (s == 0) wr(24'h000100, 32'h00160000);
      else fp_resync <= 1'b1;
      wait_sync(n);
      chk(trig_out.event_type, 32'h0);
      repeat (3) @(posedge clock);
      fp_resync <= 1'b0;
      #1 chk(busy_out, 32'h1);
      next_ev(gap);
      chk(32'(gap + 3 > dly + FE_HOLD && gap + 3 < dly + FE_HOLD + 9), 32'h1);
    end
    @(posedge clock) trig_req <= 1'b0;
  endtask
  // Two blocks pending: only the second acknowledge frees the busy.
  task automatic t_fe;
    @(posedge clock) block_done <= 1'b1;
    @(posedge clock) block_done <= 1'b0;
    @(posedge clock) block_done <= 1'b1;
    @(posedge clock) begin
      block_done <= 1'b0;
      resync_rx <= 1'b1;
    end
    @(posedge clock) resync_rx <= 1'b0;
    #1 chk(busy_out, 32'h1);
    rd(24'h000034, 32'h00000003);
    rd(24'h000034, 32'h00000002);
    @(posedge clock) readout_ack <= 1'b1;
    @(posedge clock) readout_ack <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(busy_out, 32'h1);
    @(posedge clock) readout_ack <= 1'b1;
    @(posedge clock) readout_ack <= 1'b0;
    #1 chk(busy_out, 32'h0);
  endtask
  // Counter reset inside a pause: numbering restarts at one, stamps step with the gap.
  task automatic t_rst;
    int          gap;
    int          n;
    logic [47:0] ts;
    dly <= 8'h01;
    trig_req <= 1'b1;
    wr(24'h000100, 32'h00140000);
    wait_sync(n);
    rd(24'h000034, 32'h00000004);
    @(posedge clock) counter_reset <= 1'b1;
    @(posedge clock) counter_reset <= 1'b0;
    next_ev(gap);
    chk(trig_out.event_number, 32'h1);
    ts = trig_out.time_stamp;
    next_ev(gap);
    chk(trig_out.time_stamp[31:0] - ts[31:0], 32'(gap));
    @(posedge clock) trig_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_periodic;
    t_force;
    t_fe;
    t_rst;
    end_sim;
  end
  // The whole run needs a few thousand cycles; 20000 means a hang.
  initial begin
    #500000;
    mismatches++;
    end_sim;
  end
endmodule
